// *** rtl/icmc_defs.svh ***
// Register offsets, field positions, reset values and counts for the capture mode control block
`ifndef ICMC_DEFS_SVH
`define ICMC_DEFS_SVH
`define ICMC_ADDR_W 4
`define ICMC_OFS_CONTROL 4'h0
`define ICMC_OFS_BUFFER 4'h4
`define ICMC_OFS_STATUS 4'h8
`define ICMC_OFS_MASK 4'hC
`define ICMC_CONTROL_RESET 16'h0000
`define ICMC_CONTROL_WMASK 16'h1C67
`define ICMC_TSEL_LSB 10
`define ICMC_ICI_LSB 5
`define ICMC_OV_BIT 4
`define ICMC_BNE_BIT 3
`define ICMC_MODE_LSB 0
`define ICMC_FIFO_DEPTH 4
`define ICMC_PRESCALE_4 5'h03
`define ICMC_PRESCALE_16 5'h0F
`define ICMC_ST_CAPTURE 0
`define ICMC_ST_OVERFLOW 1
`define ICMC_ST_WAKE 2
`define ICMC_ST_IRQ 3
`endif

// *** rtl/icmc_pkg.sv ***
// Types shared by the capture mode control block
package icmc_pkg;
   typedef enum logic [2:0] {
      ICMC_MODE_OFF = 3'h0,
      ICMC_MODE_BOTH = 3'h1,
      ICMC_MODE_FALL = 3'h2,
      ICMC_MODE_RISE = 3'h3,
      ICMC_MODE_RISE4 = 3'h4,
      ICMC_MODE_RISE16 = 3'h5,
      ICMC_MODE_UNUSED = 3'h6,
      ICMC_MODE_WAKE = 3'h7
   } icmc_mode_type;
   typedef enum logic [2:0] {
      ICMC_TSEL_NONE = 3'h0,
      ICMC_TSEL_T2 = 3'h1,
      ICMC_TSEL_T4 = 3'h2,
      ICMC_TSEL_T5 = 3'h3
   } icmc_tsel_type;
endpackage

// *** rtl/icmc_edge_detect.sv ***
// Edge detector on the synchronous capture input
`timescale 1ns/10ps
`default_nettype none
module icmc_edge_detect (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic pin_i,
   output logic rise_o,
   output logic fall_o
);
   logic last;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         last <= 1'b0;
      end else begin
         last <= pin_i;
      end
   end
   assign rise_o = pin_i & ~last;
   assign fall_o = ~pin_i & last;
endmodule
`default_nettype wire

// *** rtl/icmc_counter.sv ***
// Free-running capture counter advanced by the selected timer clock tick
`timescale 1ns/10ps
`default_nettype none
module icmc_counter #(
   parameter int WIDTH = 16
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic tick_i,
   output logic [WIDTH-1:0] count_o
);
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         count_o <= '0;
      end else if (tick_i) begin
         count_o <= count_o + 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** rtl/icmc_capture_control.sv ***
// Input capture channel: mode control, prescaler, interrupt pacing, capture buffer and registers
//
// Function
// R1: counter_clock_select 011/010/001 picks timer5/timer4/timer2 tick, synchronous only.
// R2: captures_per_irq 11/10/01/00 gives interrupt per 4/3/2/1 captures; ignored modes 001,111.
// R3: fifo_nonempty_flag reads 1 while an unread captured value remains.
// R4: Mode 111 makes input a wake interrupt source only; other fields ignored.
// R5: Mode 110 is unused and keeps the channel disabled.
// R6: Mode 101 captures every 16th rising edge; 100 every 4th rising edge.
// R7: Mode 011 captures every rising edge; 010 every falling edge.
// R8: Mode 001 captures every edge, rising and falling.
// R9: Mode 000 switches channel off: no captures, no capture interrupts.
// R10: capture_overflow_flag sets on capture into full buffer, held until cleared.
//
// Added by the designer: the strobed register port and the placing of the registers.
`include "icmc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module icmc_capture_control
   import icmc_pkg::*;
#(
   parameter int DEPTH = `ICMC_FIFO_DEPTH,
   parameter int WIDTH = 16
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [`ICMC_ADDR_W-1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic capture_pin_i,
   input wire logic timer2_clock_i,
   input wire logic timer4_clock_i,
   input wire logic timer5_clock_i,
   output logic capture_irq_o,
   output logic wake_o,
   output logic irq_o
);
   import icmc_pkg::*;

   localparam int PW = $clog2(DEPTH + 1);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [15:0] control;
   logic [3:0] status;
   logic [3:0] mask;
   logic [WIDTH-1:0] fifo_mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [PW-1:0] level;
   logic overflow;
   logic [4:0] prescale_cnt;
   logic [1:0] irq_cnt;
   logic rise;
   logic fall;
   logic tick;
   logic [WIDTH-1:0] count;
   logic edge_hit;
   logic capture;
   logic fifo_full;
   logic fifo_pop;
   logic irq_event;
   logic wake_event;
   logic [15:0] control_view;
   logic [15:0] next_rdata;
   icmc_mode_type mode;
   icmc_tsel_type tsel;
   logic [1:0] captures_per_irq;
   logic [4:0] prescale_max;

   assign mode = icmc_mode_type'(control[`ICMC_MODE_LSB +: 3]);
   assign tsel = icmc_tsel_type'(control[`ICMC_TSEL_LSB +: 3]);
   assign captures_per_irq = control[`ICMC_ICI_LSB +: 2];
   assign fifo_full = (level == PW'(DEPTH));
   assign fifo_pop = rd_i && (addr_i == `ICMC_OFS_BUFFER) && (level != '0);

   icmc_edge_detect u_edge (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .pin_i(capture_pin_i),
      .rise_o(rise),
      .fall_o(fall)
   );

   // Timer clocks arrive as synchronous one-cycle enables; no asynchronous source exists
   always_comb begin
      unique case (tsel)
         ICMC_TSEL_T5: tick = timer5_clock_i; // R1
         ICMC_TSEL_T4: tick = timer4_clock_i; // R1
         ICMC_TSEL_T2: tick = timer2_clock_i; // R1
         default: tick = 1'b0;
      endcase
   end

   icmc_counter #(
      .WIDTH(WIDTH)
   ) u_counter (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .tick_i(tick),
      .count_o(count)
   );

   always_comb begin
      prescale_max = 5'h00;
      unique case (mode)
         ICMC_MODE_BOTH: edge_hit = rise | fall; // R8
         ICMC_MODE_FALL: edge_hit = fall; // R7
         ICMC_MODE_RISE: edge_hit = rise; // R7
         ICMC_MODE_RISE4: begin
            edge_hit = rise; // R6
            prescale_max = `ICMC_PRESCALE_4;
         end
         ICMC_MODE_RISE16: begin
            edge_hit = rise; // R6
            prescale_max = `ICMC_PRESCALE_16;
         end
         ICMC_MODE_OFF: edge_hit = 1'b0; // R9
         ICMC_MODE_UNUSED: edge_hit = 1'b0; // R5
         ICMC_MODE_WAKE: edge_hit = 1'b0; // R4
         default: edge_hit = 1'b0;
      endcase
   end

   // Prescaled modes capture only when the edge count wraps
   assign capture = edge_hit && (prescale_cnt == prescale_max); // R6

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         prescale_cnt <= 5'h00;
      end else if (mode != ICMC_MODE_RISE4 && mode != ICMC_MODE_RISE16) begin
         prescale_cnt <= 5'h00;
      end else if (edge_hit) begin
         prescale_cnt <= (prescale_cnt == prescale_max) ? 5'h00 : prescale_cnt + 5'h01; // R6
      end
   end

   // Capture buffer; a capture into a full buffer is dropped and flagged
   always_ff @(posedge core_clk_i) begin
      if (capture && !fifo_full) begin
         fifo_mem[wr_ptr] <= count;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || mode == ICMC_MODE_OFF) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (capture && !fifo_full) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (fifo_pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         level <= level + PW'(capture && !fifo_full) - PW'(fifo_pop);
      end
   end

   // Overflow clears once software drains the buffer or turns the channel off
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         overflow <= 1'b0;
      end else if (capture && fifo_full) begin
         overflow <= 1'b1; // R10
      end else if (mode == ICMC_MODE_OFF || level == '0) begin
         overflow <= 1'b0; // R10
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         irq_cnt <= 2'h0;
      end else if (mode == ICMC_MODE_OFF || mode == ICMC_MODE_UNUSED) begin
         irq_cnt <= 2'h0;
      end else if (capture && mode != ICMC_MODE_BOTH) begin
         irq_cnt <= (irq_cnt == captures_per_irq) ? 2'h0 : irq_cnt + 2'h1; // R2
      end
   end

   // Every-edge mode ignores the pacing field and interrupts on each capture
   assign irq_event = capture && (mode == ICMC_MODE_BOTH || irq_cnt == captures_per_irq); // R2
   assign wake_event = (mode == ICMC_MODE_WAKE) && (rise | fall); // R4

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         capture_irq_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         capture_irq_o <= irq_event; // R9
         wake_o <= wake_event; // R4
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         control <= `ICMC_CONTROL_RESET;
      end else if (wr_i && addr_i == `ICMC_OFS_CONTROL) begin
         control <= wdata_i & `ICMC_CONTROL_WMASK;
      end
   end

   // Set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         status <= 4'h0;
      end else begin
         status <= (status & ~((wr_i && addr_i == `ICMC_OFS_STATUS) ? wdata_i[3:0] : 4'h0))
                   | {irq_event, wake_event, capture && fifo_full, capture};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         mask <= 4'h0;
      end else if (wr_i && addr_i == `ICMC_OFS_MASK) begin
         mask <= wdata_i[3:0];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status & mask);
      end
   end

   always_comb begin
      control_view = control;
      control_view[`ICMC_OV_BIT] = overflow; // R10
      control_view[`ICMC_BNE_BIT] = (level != '0); // R3
   end

   always_comb begin
      next_rdata = 16'h0000;
      if (rd_i) begin
         unique case (addr_i)
            `ICMC_OFS_CONTROL: next_rdata = control_view;
            `ICMC_OFS_BUFFER: next_rdata = (level != '0) ? 16'(fifo_mem[rd_ptr]) : 16'h0000;
            `ICMC_OFS_STATUS: next_rdata = {12'h000, status};
            `ICMC_OFS_MASK: next_rdata = {12'h000, mask};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// *** verification/icmc_capture_control_sva.sv ***
// Port checker for the capture mode control block
`include "icmc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module icmc_capture_control_sva (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic capture_pin_i,
   input wire logic capture_irq_o,
   input wire logic wake_o
);
   logic [2:0] m;
   logic pq;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // Shadow of the mode field and pin history, both cleared like the design's
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         m <= 3'h0;
         pq <= 1'h0;
      end else begin
         pq <= capture_pin_i;
         if (wr_i && addr_i == `ICMC_OFS_CONTROL) begin
            m <= wdata_i[2:0];
         end
      end
   end
   sequence s_edge; capture_pin_i != pq; endsequence
   sequence s_wake; m == 3'h7 ##0 s_edge; endsequence
   property p_off; $past(m) == 3'h0 |-> !capture_irq_o; endproperty
   property p_unused; $past(m) == 3'h6 |-> !capture_irq_o && !wake_o; endproperty
   property p_wake_only; $past(m) == 3'h7 |-> !capture_irq_o; endproperty
   property p_wake; s_wake |=> wake_o; endproperty
   property p_wake_src; wake_o |-> $past(m) == 3'h7 && $past(capture_pin_i != pq); endproperty
   property p_rise; capture_irq_o && $past(m) == 3'h3 |-> $past(capture_pin_i && !pq); endproperty
   property p_fall; capture_irq_o && $past(m) == 3'h2 |-> $past(!capture_pin_i && pq); endproperty
   property p_both; capture_irq_o && $past(m) == 3'h1 |-> $past(capture_pin_i != pq); endproperty
   property p_pre; capture_irq_o && $past(m) inside {3'h4, 3'h5} |-> $past(capture_pin_i && !pq); endproperty
   property p_rd_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
   a_off: assert property (p_off) else $error("capture irq while off");
   a_unused: assert property (p_unused) else $error("activity in unused mode");
   a_wake_only: assert property (p_wake_only) else $error("capture irq in wake mode");
   a_wake: assert property (p_wake) else $error("missing wake pulse");
   a_wake_src: assert property (p_wake_src) else $error("stray wake pulse");
   a_rise: assert property (p_rise) else $error("irq without rising edge");
   a_fall: assert property (p_fall) else $error("irq without falling edge");
   a_both: assert property (p_both) else $error("irq without edge");
   a_pre: assert property (p_pre) else $error("prescaled irq without rising edge");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule
`default_nettype wire

// *** verification/icmc_pin_model.sv ***
// Far-side model: capture pin and timer clock ticks
`timescale 1ns/10ps
`default_nettype none
module icmc_pin_model (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   output logic capture_pin_o,
   output logic timer2_clock_o,
   output logic timer4_clock_o,
   output logic timer5_clock_o
);
   logic [1:0] div = 2'h0;
   initial capture_pin_o = 1'b0;
   always @(posedge core_clk_i) begin
      div <= nrst_i ? div + 2'h1 : 2'h0;
   end
   // Periods of 1, 2 and 4 cycles give a fixed count between evenly spaced captures
   assign timer2_clock_o = nrst_i;
   assign timer4_clock_o = div[0];
   assign timer5_clock_o = div == 2'h3;
   task automatic toggle(input int n);
      repeat (n) begin
         @(posedge core_clk_i);
         capture_pin_o <= ~capture_pin_o;
         @(posedge core_clk_i);
      end
   endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking testbench for the capture mode control block
`include "icmc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import icmc_pkg::*;
   typedef struct {int m; int captures_per_irq; int tog; int irq; int wk;} icmc_row_type;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] rdata_o, d, v;
   logic pin, t2, t4, t5, capture_irq_o, wake_o, irq_o;
   int n_mismatch = 0, n_tests = 0, n_irq = 0, n_wake = 0, s_irq, s_wake;
   icmc_row_type rows [11] = '{'{0, 3, 8, 0, 0}, '{6, 0, 8, 0, 0}, '{7, 3, 8, 0, 8}, '{3, 0, 4, 2, 0},
      '{2, 0, 4, 2, 0}, '{1, 3, 4, 4, 0}, '{4, 0, 16, 2, 0}, '{5, 0, 32, 1, 0}, '{3, 1, 8, 2, 0},
      '{3, 2, 8, 1, 0}, '{3, 3, 8, 1, 0}};
   icmc_pin_model icmc_pin_model_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .capture_pin_o(pin),
      .timer2_clock_o(t2), .timer4_clock_o(t4), .timer5_clock_o(t5));
   icmc_capture_control icmc_capture_control_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .capture_pin_i(pin), .timer2_clock_i(t2), .timer4_clock_i(t4), .timer5_clock_i(t5),
      .capture_irq_o(capture_irq_o), .wake_o(wake_o), .irq_o(irq_o));
   always #50 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      if (capture_irq_o === 1'b1) n_irq++;
      if (wake_o === 1'b1) n_wake++;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] x);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= x;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] x);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 x = rdata_o;
   endtask
   task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_n(input int g, input int e);
      chk_v(16'(g), 16'(e));
   endtask
   task automatic test_done;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      rd(`ICMC_OFS_CONTROL, d);
      chk_v(d, `ICMC_CONTROL_RESET);
      wr(`ICMC_OFS_CONTROL, 16'hFFFF);
      rd(`ICMC_OFS_CONTROL, d);
      chk_v(d, `ICMC_CONTROL_WMASK);
      rd(4'h2, d);
      chk_v(d, 16'h0000);
      $display("register test done");
      // Mode 000 between rows flushes the buffer so no row runs into a full buffer
      foreach (rows[i]) begin
         wr(`ICMC_OFS_CONTROL, 16'h0000);
         wr(`ICMC_OFS_CONTROL, 16'(rows[i].captures_per_irq * 32 + rows[i].m));
         #1 s_irq = n_irq;
         s_wake = n_wake;
         icmc_pin_model_inst.toggle(rows[i].tog);
         repeat (3) @(posedge core_clk_i);
         #1 chk_n(n_irq - s_irq, rows[i].irq);
         chk_n(n_wake - s_wake, rows[i].wk);
         $display("row %0d done", i);
      end
      for (int t = 1; t < 4; t++) begin
         wr(`ICMC_OFS_CONTROL, 16'h0000);
         wr(`ICMC_OFS_CONTROL, 16'(t * 1024 + 3));
         icmc_pin_model_inst.toggle(4);
         rd(`ICMC_OFS_BUFFER, d);
         rd(`ICMC_OFS_BUFFER, v);
         chk_v(v - d, 16'(4 >> (t - 1)));
      end
      $display("clock select test done");
      wr(`ICMC_OFS_CONTROL, 16'h0000);
      wr(`ICMC_OFS_MASK, 16'h0001);
      wr(`ICMC_OFS_CONTROL, 16'h0C03);
      icmc_pin_model_inst.toggle(10);
      rd(`ICMC_OFS_CONTROL, d);
      chk_v(d, 16'h0C1B);
      chk_v({15'h0, irq_o}, 16'h0001);
      wr(`ICMC_OFS_STATUS, 16'h000F);
      repeat (2) @(posedge core_clk_i);
      #1 chk_v({15'h0, irq_o}, 16'h0000);
      repeat (4) rd(`ICMC_OFS_BUFFER, d);
      rd(`ICMC_OFS_CONTROL, d);
      chk_v(d, 16'h0C03);
      rd(`ICMC_OFS_BUFFER, d);
      chk_v(d, 16'h0000);
      wr(`ICMC_OFS_MASK, 16'h0000);
      icmc_pin_model_inst.toggle(2);
      repeat (2) @(posedge core_clk_i);
      #1 chk_v({15'h0, irq_o}, 16'h0000);
      rd(`ICMC_OFS_STATUS, d);
      chk_v(d, 16'h0009);
      $display("status test done");
      // Reset in mid-run must clear the sticky status and the control register
      @(posedge core_clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      rd(`ICMC_OFS_STATUS, d);
      chk_v(d, 16'h0000);
      rd(`ICMC_OFS_CONTROL, d);
      chk_v(d, `ICMC_CONTROL_RESET);
      $display("reset test done");
      test_done;
   end
   initial begin
      repeat (5000) @(posedge core_clk_i);
      n_mismatch++;
      test_done;
   end
endmodule
bind icmc_capture_control icmc_capture_control_sva icmc_capture_control_sva_inst (.core_clk_i(core_clk_i),
   .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .capture_pin_i(capture_pin_i), .capture_irq_o(capture_irq_o), .wake_o(wake_o));
`default_nettype wire
